/* File: swl_bus_master.sv */
// bus master model that drives the shared wire of the slave link
`timescale 1ns/10ps
module swl_bus_master (
    input  wire logic clk_sys,
    input  wire logic line_in,
    output logic      master_pull
);
    // ==========================================================
    // slot timing in clock cycles
    // slots trimmed below the nominal 60 us to bound run time;
    // a write 0 still holds past the 30 us sample point
    localparam int W0_LOW  = 310;
    localparam int W1_LOW  = 50;
    localparam int WR_SLOT = 320;
    localparam int RD_LOW  = 10;
    localparam int RD_SLOT = 160;
    localparam int RD_SAMP = 120;

    initial master_pull = 1'b0;

    // ==========================================================
    // reset pulse, then time the presence pulse seen on the wire
    task automatic bus_reset_pulse(input int low_cyc, output int p_rise,
                                   output int p_fall);
        p_rise = -1;
        p_fall = -1;
        @(negedge clk_sys);
        master_pull = 1'b1;
        repeat (low_cyc) @(negedge clk_sys);
        master_pull = 1'b0;
        for (int k = 0; k < 1600; k++) begin
            @(posedge clk_sys);
            #1;
            if (line_in === 1'b0 && p_rise < 0) p_rise = k;
            if (line_in === 1'b1 && p_rise >= 0 && p_fall < 0) p_fall = k;
        end
    endtask

    // plain low level of a given length, then idle high
    task automatic line_low(input int cyc);
        @(negedge clk_sys);
        master_pull = 1'b1;
        repeat (cyc) @(negedge clk_sys);
        master_pull = 1'b0;
        repeat (20) @(negedge clk_sys);
    endtask

    // write slot: short low for 1, long low for 0
    task automatic write_bit(input logic b);
        @(negedge clk_sys);
        master_pull = 1'b1;
        repeat (b ? W1_LOW : W0_LOW) @(negedge clk_sys);
        master_pull = 1'b0;
        repeat (b ? WR_SLOT - W1_LOW : WR_SLOT - W0_LOW) @(negedge clk_sys);
    endtask

    // read slot: count low cycles so the hold time is checked too
    task automatic read_bit(output logic b, output int n_low);
        n_low = 0;
        b = 1'bx;
        @(negedge clk_sys);
        master_pull = 1'b1;
        for (int k = 0; k < RD_SLOT; k++) begin
            @(posedge clk_sys);
            #1;
            if (line_in === 1'b0) n_low++;
            if (k == RD_SAMP) b = line_in;
            @(negedge clk_sys);
            if (k == RD_LOW - 1) master_pull = 1'b0;
        end
    endtask

    // whole words, least significant bit first
    task automatic write_bits(input logic [63:0] v, input int n);
        for (int i = 0; i < n; i++) write_bit(v[i]);
    endtask

    // bad counts slots whose low time is not 1 us or 15 us
    task automatic read_bits(input int n, output logic [63:0] v,
                             output int bad);
        logic b;
        int   nl;
        v = 64'hFFFF_FFFF_FFFF_FFFF;
        bad = 0;
        for (int i = 0; i < n; i++) begin
            read_bit(b, nl);
            v[i] = b;
            // samples follow each edge, so the half cycle of our own pull
            // before the first edge is never counted
            if (nl != (b === 1'b1 ? RD_LOW
                       : int'(swl_pkg::READ_VALID_CYC) - 1)) bad++;
        end
    endtask
endmodule

/* File: swl_pkg.sv */
// constants, commands and states for the single-wire slave link
package swl_pkg;

    // ==========================================================
    // clock and timing
    localparam int CLK_KHZ       = 10000;
    localparam int CYC_PER_US    = CLK_KHZ / 1000;
    localparam int PRES_WAIT_US  = 30;   // presence_wait_time, mid of range
    localparam int PRES_LOW_US   = 120;  // presence_low_time, mid of range
    localparam int SAMPLE_US     = 30;   // write slot sampling point
    localparam int READ_VALID_US = 15;   // read_valid_window
    localparam int RST_DET_US    = 240;  // beyond the longest write 0 slot

    localparam logic [15:0] PRES_WAIT_CYC  = 16'(PRES_WAIT_US * CYC_PER_US);
    localparam logic [15:0] PRES_LOW_CYC   = 16'(PRES_LOW_US * CYC_PER_US);
    localparam logic [15:0] SAMPLE_CYC     = 16'(SAMPLE_US * CYC_PER_US);
    localparam logic [15:0] READ_VALID_CYC = 16'(READ_VALID_US * CYC_PER_US);
    localparam logic [15:0] RST_DET_CYC    = 16'(RST_DET_US * CYC_PER_US);

    // ==========================================================
    // commands and counts
    localparam logic [7:0] CMD_READ_ID = 8'h33;
    localparam logic [7:0] CMD_MATCH   = 8'h55;
    localparam logic [7:0] CMD_SEARCH  = 8'hF0;
    localparam logic [7:0] CMD_SKIP    = 8'hCC;
    localparam logic [7:0] CRC_POLY_LSB = 8'h8C;  // reflected x^8+x^5+x^4+1
    localparam logic [5:0] CMD_LAST_BIT = 6'h07;
    localparam logic [5:0] ID_LAST_BIT  = 6'h3F;
    localparam logic [1:0] PH_TRUE      = 2'h0;
    localparam logic [1:0] PH_COMP      = 2'h1;
    localparam logic [1:0] PH_WRITE     = 2'h2;

    // ==========================================================
    // link states
    typedef enum logic [2:0] {
        SWL_IDLE   = 3'b000,
        SWL_PWAIT  = 3'b001,
        SWL_PLOW   = 3'b010,
        SWL_CMD    = 3'b011,
        SWL_RDID   = 3'b100,
        SWL_MATCH  = 3'b101,
        SWL_SEARCH = 3'b110,
        SWL_SEL    = 3'b111
    } swl_state_t;

endpackage

/* File: swl_slave_link.sv */
// single-wire slave link: reset/presence, bit slots, identity commands
`timescale 1ns/10ps
module swl_slave_link #(
    parameter logic [7:0]  FAMILY = 8'h5A,            // arbitrary value
    parameter logic [47:0] SERIAL = 48'h0000_1234_5678 // arbitrary value
) (
    input  wire logic       clk_sys,
    input  wire logic       rst,
    input  wire logic       line_in,
    output logic            line_out,
    output logic            line_oe,
    output logic            selected,
    output logic [7:0]      rom_cmd,
    output logic            bus_reset
);

    // ==========================================================
    // identity with check byte, serial shifted lsb first
    function automatic logic [7:0] swl_crc8(input logic [55:0] d);
        logic [7:0] c;
        logic       fb;
        c = 8'h00;
        for (int i = 0; i < 56; i++) begin
            fb = c[0] ^ d[i];
            c = {1'b0, c[7:1]} ^ (fb ? swl_pkg::CRC_POLY_LSB : 8'h00);
        end
        return c;
    endfunction

    localparam logic [63:0] ID = {swl_crc8({SERIAL, FAMILY}), SERIAL,
                                  FAMILY};

    swl_pkg::swl_state_t state;
    logic        line_q;
    logic [15:0] low_cnt;
    logic [15:0] tmr;
    logic [15:0] slot_cnt;
    logic        slot_act;
    logic [5:0]  bit_cnt;
    logic [1:0]  phase;
    logic [7:0]  cmd_sr;
    logic [7:0]  next_cmd;
    logic        id_bit;
    logic        rd_slot;
    logic        rd_bit;
    logic        fall;
    logic        in_slots;
    logic        slot_start;
    logic        sample_now;
    logic        rd_end;
    logic        rst_arm;
    logic        reset_rise;
    logic        pres_next;
    logic        rd_next;

    // ==========================================================
    // line edges and bus reset detection
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            line_q <= 1'b1;
        end else begin
            line_q <= line_in;
        end
    end

    // saturating low-time counter, independent of state
    always_ff @(posedge clk_sys) begin
        if (rst || line_in) begin
            low_cnt <= 16'h0000;
        end else if (low_cnt != swl_pkg::RST_DET_CYC) begin
            low_cnt <= low_cnt + 16'h0001;
        end
    end

    assign rst_arm    = (low_cnt == swl_pkg::RST_DET_CYC);
    assign reset_rise = rst_arm && line_in && !line_q;
    // own drive is excluded, so only master falls open a slot
    assign fall       = line_q && !line_in && !line_oe;
    assign in_slots   = (state == swl_pkg::SWL_CMD) ||
                        (state == swl_pkg::SWL_RDID) ||
                        (state == swl_pkg::SWL_MATCH) ||
                        (state == swl_pkg::SWL_SEARCH);
    assign slot_start = fall && in_slots;

    // ==========================================================
    // slot kind and bit to send
    assign id_bit  = ID[bit_cnt];
    assign rd_slot = (state == swl_pkg::SWL_RDID) ||
                     (state == swl_pkg::SWL_SEARCH &&
                      phase != swl_pkg::PH_WRITE);
    assign rd_bit  = (state == swl_pkg::SWL_SEARCH &&
                      phase == swl_pkg::PH_COMP) ? !id_bit : id_bit;
    assign next_cmd = {line_in, cmd_sr[7:1]};

    // internal delay timer, restarted by each master fall in the command, read-id, match or search state
    always_ff @(posedge clk_sys) begin
        if (rst || reset_rise) begin
            slot_act <= 1'b0;
            slot_cnt <= 16'h0000;
        end else if (slot_start) begin
            slot_act <= 1'b1;
            slot_cnt <= 16'h0001;
        end else if (sample_now || rd_end) begin
            slot_act <= 1'b0;
        end else if (slot_act) begin
            slot_cnt <= slot_cnt + 16'h0001;
        end
    end

    // sample well after write-1 low ends and before write-0 low ends
    assign sample_now = slot_act && !rd_slot &&
                        slot_cnt == swl_pkg::SAMPLE_CYC;
    assign rd_end     = slot_act && rd_slot &&
                        slot_cnt == swl_pkg::READ_VALID_CYC;

    // ==========================================================
    // protocol state machine
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            state   <= swl_pkg::SWL_IDLE;
            tmr     <= 16'h0000;
            bit_cnt <= 6'h00;
            phase   <= swl_pkg::PH_TRUE;
            cmd_sr  <= 8'h00;
        end else if (reset_rise) begin
            state   <= swl_pkg::SWL_PWAIT;
            tmr     <= 16'h0000;
            bit_cnt <= 6'h00;
            phase   <= swl_pkg::PH_TRUE;
        end else begin
            case (state)
                swl_pkg::SWL_PWAIT: begin
                    tmr <= tmr + 16'h0001;
                    if (tmr == swl_pkg::PRES_WAIT_CYC - 16'h0001) begin
                        state <= swl_pkg::SWL_PLOW;
                        tmr   <= 16'h0000;
                    end
                end
                swl_pkg::SWL_PLOW: begin
                    tmr <= tmr + 16'h0001;
                    if (tmr == swl_pkg::PRES_LOW_CYC - 16'h0001) begin
                        state <= swl_pkg::SWL_CMD;
                    end
                end
                swl_pkg::SWL_CMD: begin
                    if (sample_now) begin
                        cmd_sr  <= next_cmd;
                        bit_cnt <= bit_cnt + 6'h01;
                        if (bit_cnt == swl_pkg::CMD_LAST_BIT) begin
                            bit_cnt <= 6'h00;
                            // unknown codes fall silent until reset
                            if (next_cmd == swl_pkg::CMD_READ_ID) begin
                                state <= swl_pkg::SWL_RDID;
                            end else if (next_cmd == swl_pkg::CMD_MATCH) begin
                                state <= swl_pkg::SWL_MATCH;
                            end else if (next_cmd == swl_pkg::CMD_SEARCH) begin
                                state <= swl_pkg::SWL_SEARCH;
                            end else if (next_cmd == swl_pkg::CMD_SKIP) begin
                                state <= swl_pkg::SWL_SEL;
                            end else begin
                                state <= swl_pkg::SWL_IDLE;
                            end
                        end
                    end
                end
                swl_pkg::SWL_RDID: begin
                    if (rd_end) begin
                        bit_cnt <= bit_cnt + 6'h01;
                        if (bit_cnt == swl_pkg::ID_LAST_BIT) begin
                            state <= swl_pkg::SWL_SEL;
                        end
                    end
                end
                swl_pkg::SWL_MATCH: begin
                    if (sample_now) begin
                        bit_cnt <= bit_cnt + 6'h01;
                        if (line_in != id_bit) begin
                            state <= swl_pkg::SWL_IDLE;
                        end else if (bit_cnt == swl_pkg::ID_LAST_BIT) begin
                            state <= swl_pkg::SWL_SEL;
                        end
                    end
                end
                swl_pkg::SWL_SEARCH: begin
                    if (rd_end) begin
                        phase <= phase + 2'h1;
                    end else if (sample_now) begin
                        phase   <= swl_pkg::PH_TRUE;
                        bit_cnt <= bit_cnt + 6'h01;
                        if (line_in != id_bit) begin
                            state <= swl_pkg::SWL_IDLE;
                        end else if (bit_cnt == swl_pkg::ID_LAST_BIT) begin
                            state <= swl_pkg::SWL_SEL;
                        end
                    end
                end
                default: begin
                    // idle and selected only leave on a bus reset
                    state <= state;
                end
            endcase
        end
    end

    // ==========================================================
    // open-drain driver: presence, or a 0 in a read slot
    assign pres_next = (state == swl_pkg::SWL_PWAIT &&
                        tmr == swl_pkg::PRES_WAIT_CYC - 16'h0001) ||
                       (state == swl_pkg::SWL_PLOW &&
                        tmr != swl_pkg::PRES_LOW_CYC - 16'h0001);
    assign rd_next   = (slot_start && rd_slot && !rd_bit) ||
                       (line_oe && slot_act && rd_slot &&
                        slot_cnt < swl_pkg::READ_VALID_CYC - 16'h0001);

    always_ff @(posedge clk_sys) begin
        if (rst || reset_rise) begin
            line_oe <= 1'b0;
        end else begin
            line_oe <= pres_next || rd_next;
        end
    end

    // user-side status, all registered
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            line_out  <= 1'b0;
            selected  <= 1'b0;
            rom_cmd   <= 8'h00;
            bus_reset <= 1'b0;
        end else begin
            line_out  <= 1'b0;
            selected  <= (state == swl_pkg::SWL_SEL) && !reset_rise;
            bus_reset <= reset_rise;
            if (state == swl_pkg::SWL_CMD && sample_now &&
                bit_cnt == swl_pkg::CMD_LAST_BIT) begin
                rom_cmd <= next_cmd;
            end
        end
    end

    // ==========================================================
    // checks
    property p_reset_to_wait;
        @(posedge clk_sys) disable iff (rst)
        reset_rise |=> state == swl_pkg::SWL_PWAIT && !line_oe;
    endproperty
    a_reset_to_wait: assert property (p_reset_to_wait)
        else $error("bus reset did not start presence wait");

    property p_wait_quiet;
        @(posedge clk_sys) disable iff (rst)
        $rose(state == swl_pkg::SWL_PWAIT) |-> !line_oe [*8];
    endproperty
    a_wait_quiet: assert property (p_wait_quiet)
        else $error("line driven during presence wait");

    property p_pres_end;
        @(posedge clk_sys) disable iff (rst)
        (state == swl_pkg::SWL_PLOW &&
         tmr == swl_pkg::PRES_LOW_CYC - 16'h0001 && !reset_rise)
        |=> state == swl_pkg::SWL_CMD && !line_oe;
    endproperty
    a_pres_end: assert property (p_pres_end)
        else $error("presence pulse did not end on time");

    property p_drive_owner;
        @(posedge clk_sys) disable iff (rst)
        line_oe |-> state == swl_pkg::SWL_PLOW || slot_act;
    endproperty
    a_drive_owner: assert property (p_drive_owner)
        else $error("line driven outside presence or slot");

    property p_read_window;
        @(posedge clk_sys) disable iff (rst)
        (line_oe && state != swl_pkg::SWL_PLOW)
        |-> slot_cnt < swl_pkg::READ_VALID_CYC;
    endproperty
    a_read_window: assert property (p_read_window)
        else $error("read zero held past valid window");

    property p_read_zero;
        @(posedge clk_sys) disable iff (rst)
        (slot_start && rd_slot && !rd_bit) |=> line_oe [*8];
    endproperty
    a_read_zero: assert property (p_read_zero)
        else $error("read zero not driven");

    property p_match_fail;
        @(posedge clk_sys) disable iff (rst)
        (state == swl_pkg::SWL_MATCH && sample_now && line_in != id_bit &&
         !reset_rise) |=> state == swl_pkg::SWL_IDLE;
    endproperty
    a_match_fail: assert property (p_match_fail)
        else $error("mismatching identity not dropped");

    property p_search_fail;
        @(posedge clk_sys) disable iff (rst)
        (state == swl_pkg::SWL_SEARCH && sample_now && line_in != id_bit &&
         !reset_rise) |=> state == swl_pkg::SWL_IDLE;
    endproperty
    a_search_fail: assert property (p_search_fail)
        else $error("search loser kept taking part");

    property p_skip;
        @(posedge clk_sys) disable iff (rst)
        (state == swl_pkg::SWL_CMD && sample_now && !reset_rise &&
         bit_cnt == swl_pkg::CMD_LAST_BIT && next_cmd == swl_pkg::CMD_SKIP)
        |=> state == swl_pkg::SWL_SEL ##1 selected;
    endproperty
    a_skip: assert property (p_skip)
        else $error("skip did not select");

    property p_lsb_first;
        @(posedge clk_sys) disable iff (rst)
        (state == swl_pkg::SWL_CMD && sample_now && !reset_rise)
        |=> cmd_sr[7] == $past(line_in);
    endproperty
    a_lsb_first: assert property (p_lsb_first)
        else $error("command bit not shifted in lsb first");

    c_presence: cover property (@(posedge clk_sys) disable iff (rst)
        $rose(state == swl_pkg::SWL_PLOW));
    c_read_id: cover property (@(posedge clk_sys) disable iff (rst)
        state == swl_pkg::SWL_RDID ##1 state == swl_pkg::SWL_SEL);
    c_match: cover property (@(posedge clk_sys) disable iff (rst)
        state == swl_pkg::SWL_MATCH ##1 state == swl_pkg::SWL_SEL);
    c_search: cover property (@(posedge clk_sys) disable iff (rst)
        state == swl_pkg::SWL_SEARCH ##1 state == swl_pkg::SWL_SEL);

endmodule

/* File: swl_slave_link_tb.sv */
// self-checking bench for the single-wire slave link
`timescale 1ns/10ps
module swl_slave_link_tb;
    localparam logic [7:0]  FAM = 8'hC3;            // arbitrary value
    localparam logic [47:0] SER = 48'h0123_89AB_4D5E; // arbitrary value

    logic        clk_sys;
    logic        rst;
    logic        line_in;
    logic        line_out;
    logic        line_oe;
    logic        selected;
    logic        bus_reset;
    logic        master_pull;
    logic [7:0]  rom_cmd;
    logic [63:0] id_exp;
    int          err_total;
    int          n_compared;
    int          br_seen = 0;

    // open-drain wire with pull-up: low if anyone pulls
    assign line_in = !(line_oe | master_pull);

    swl_slave_link #(.FAMILY(FAM), .SERIAL(SER)) u_swl_slave_link (
        .clk_sys   (clk_sys),
        .rst       (rst),
        .line_in   (line_in),
        .line_out  (line_out),
        .line_oe   (line_oe),
        .selected  (selected),
        .rom_cmd   (rom_cmd),
        .bus_reset (bus_reset)
    );

    swl_bus_master u_swl_bus_master (
        .clk_sys     (clk_sys),
        .line_in     (line_in),
        .master_pull (master_pull)
    );

    // count reset pulses so width and count can be judged
    always @(posedge clk_sys) if (bus_reset === 1'b1) br_seen <= br_seen + 1;

    // ==========================================================
    // helpers
    function automatic logic [7:0] crc_of(input logic [55:0] d);
        logic [7:0] c;
        logic       fb;
        c = 8'h00;
        for (int i = 0; i < 56; i++) begin
            fb = c[0] ^ d[i];
            c = c >> 1;
            if (fb) c = c ^ swl_pkg::CRC_POLY_LSB;
        end
        return c;
    endfunction

    task automatic chk(input string what, input logic [63:0] seen,
                       input logic [63:0] exp);
        n_compared++;
        if (seen !== exp) begin
            err_total++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic done(input string name);
        $display("test %s ended, mismatches so far %0d", name, err_total);
    endtask

    task automatic close_out();
        $display("comparisons %0d mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask

    // reset pulse with presence timing and one-cycle reset flag
    task automatic do_reset(input int low_cyc);
        int r;
        int f;
        int b0;
        b0 = br_seen;
        u_swl_bus_master.bus_reset_pulse(low_cyc, r, f);
        // release edge is sample 0, so the counts equal the package delays
        chk("presence start", r, swl_pkg::PRES_WAIT_CYC);
        chk("presence end", f,
            swl_pkg::PRES_WAIT_CYC + swl_pkg::PRES_LOW_CYC);
        chk("reset pulse count", br_seen - b0, 1);
        chk("selected after reset", selected, 1'b0);
    endtask

    // ==========================================================
    // scenarios
    task automatic t_idle_silent();
        logic b;
        int   nl;
        u_swl_bus_master.read_bit(b, nl);
        chk("silent before reset", nl, 10);
        chk("line_out", line_out, 1'b0);
        chk("rom_cmd at reset", rom_cmd, 8'h00);
        done("idle_silent");
    endtask

    task automatic t_skip_and_short_low();
        logic [63:0] v;
        int          bad;
        int          b0;
        do_reset(4800);
        u_swl_bus_master.write_bits(64'hA5, 8);
        u_swl_bus_master.read_bits(8, v, bad);
        chk("unknown code silent", v[7:0], 8'hFF);
        chk("unknown code selected", selected, 1'b0);
        do_reset(2500);
        u_swl_bus_master.write_bits(64'(swl_pkg::CMD_SKIP), 8);
        chk("skip selected", selected, 1'b1);
        chk("skip code", rom_cmd, swl_pkg::CMD_SKIP);
        b0 = br_seen;
        u_swl_bus_master.line_low(2000);
        chk("short low no reset", br_seen - b0, 0);
        chk("short low keeps selected", selected, 1'b1);
        done("skip_and_short_low");
    endtask

    task automatic t_read_id();
        logic [63:0] v;
        int          bad;
        do_reset(2500);
        // only one slave sits on this wire
        u_swl_bus_master.write_bits(64'(swl_pkg::CMD_READ_ID), 8);
        u_swl_bus_master.read_bits(64, v, bad);
        chk("identity", v, id_exp);
        chk("read hold times", bad, 0);
        chk("read id code", rom_cmd, swl_pkg::CMD_READ_ID);
        chk("read id selected", selected, 1'b1);
        done("read_id");
    endtask

    task automatic t_match();
        logic [63:0] v;
        int          bad;
        do_reset(2500);
        u_swl_bus_master.write_bits(64'(swl_pkg::CMD_MATCH), 8);
        u_swl_bus_master.write_bits(id_exp, 64);
        chk("match selected", selected, 1'b1);
        do_reset(2500);
        u_swl_bus_master.write_bits(64'(swl_pkg::CMD_MATCH), 8);
        u_swl_bus_master.write_bits(id_exp ^ 64'h4, 3);
        u_swl_bus_master.read_bits(8, v, bad);
        chk("mismatch silent", v[7:0], 8'hFF);
        chk("mismatch selected", selected, 1'b0);
        done("match");
    endtask

    task automatic t_search();
        logic [63:0] v;
        int          bad;
        int          wrong;
        wrong = 0;
        do_reset(2500);
        u_swl_bus_master.write_bits(64'(swl_pkg::CMD_SEARCH), 8);
        for (int i = 0; i < 64; i++) begin
            u_swl_bus_master.read_bits(2, v, bad);
            if (v[1:0] !== {~id_exp[i], id_exp[i]} || bad != 0) wrong++;
            u_swl_bus_master.write_bit(id_exp[i]);
        end
        chk("search bit pairs", wrong, 0);
        chk("search selected", selected, 1'b1);
        do_reset(2500);
        u_swl_bus_master.write_bits(64'(swl_pkg::CMD_SEARCH), 8);
        u_swl_bus_master.read_bits(2, v, bad);
        u_swl_bus_master.write_bit(~id_exp[0]);
        u_swl_bus_master.read_bits(2, v, bad);
        chk("search dropout silent", v[1:0], 2'b11);
        chk("search dropout selected", selected, 1'b0);
        done("search");
    endtask

    // ==========================================================
    // clock and main sequence
    initial begin
        clk_sys = 1'b0;
        forever #50 clk_sys = ~clk_sys;
    end

    initial begin
        rst = 1'b1;
        err_total = 0;
        n_compared = 0;
        id_exp = {crc_of({SER, FAM}), SER, FAM};
        repeat (2) @(posedge clk_sys);
        @(negedge clk_sys);
        rst = 1'b0;
        t_idle_silent();
        t_skip_and_short_low();
        t_read_id();
        t_match();
        t_search();
        close_out();
    end
endmodule
